// file: hw/sdd_defines.vh
`ifndef SDD_DEFINES_VH
`define SDD_DEFINES_VH

// operation codes handled here
`define SDD_OP_REZERO 8'h01
`define SDD_OP_SEEK6 8'h0B
`define SDD_OP_RESERVE 8'h16
`define SDD_OP_DIAG 8'h1D
`define SDD_OP_SEEK10 8'h2B

// command kinds after decode
`define SDD_KIND_NONE 3'h0
`define SDD_KIND_RESERVE 3'h1
`define SDD_KIND_REZERO 3'h2
`define SDD_KIND_SEEK 3'h3
`define SDD_KIND_DIAG 3'h4

// status byte values
`define SDD_ST_GOOD 8'h00
`define SDD_ST_CHECK 8'h02
`define SDD_ST_CONFLICT 8'h18

// sense key and code values
`define SDD_SK_NONE 4'h0
`define SDD_SK_ILLEGAL 4'h5
`define SDD_ASC_NONE 8'h00
`define SDD_ASC_BAD_OPCODE 8'h20
`define SDD_ASC_BAD_LBA 8'h21
`define SDD_ASC_BAD_FIELD 8'h24

// field positions within byte 1
`define SDD_RSV_THIRD_BIT 4
`define SDD_RSV_TPID_MSB 3
`define SDD_RSV_TPID_LSB 1
`define SDD_RSV_EXTENT_BIT 0
`define SDD_DIAG_SELF_TEST_BIT 2
`define SDD_DIAG_DEV_OFFLINE_BIT 1
`define SDD_DIAG_UNIT_OFFLINE_BIT 0
`define SDD_SEEK6_LBA_MSB 4

// reset values
`define SDD_RST_HOLDER 3'h0
`define SDD_RST_LBA 32'h00000000

`endif

// file: hw/sdd_cdb_check.v
`timescale 1ns/1ps
`include "sdd_defines.vh"

// pure field decode of one captured descriptor block
module sdd_cdb_check
(
    input wire [79:0] cdb,
    output reg [2:0] kind,
    output reg opcode_bad,
    output reg field_bad,
    output reg [31:0] lba,
    output wire third_party,
    output wire [2:0] tp_id,
    output wire self_test
);

    wire [7:0] b0 = cdb[7:0];
    wire [7:0] b1 = cdb[15:8];
    wire [7:0] b2 = cdb[23:16];
    wire [7:0] b3 = cdb[31:24];
    wire [7:0] b4 = cdb[39:32];
    wire [7:0] b5 = cdb[47:40];
    wire [7:0] b6 = cdb[55:48];
    wire [7:0] b7 = cdb[63:56];
    wire [7:0] b8 = cdb[71:64];
    wire [15:0] param_len = {b3, b4}; // msb first

    assign third_party = b1[`SDD_RSV_THIRD_BIT];
    assign tp_id = b1[`SDD_RSV_TPID_MSB:`SDD_RSV_TPID_LSB];
    assign self_test = b1[`SDD_DIAG_SELF_TEST_BIT];

    // each opcode checks its own reserved fields; lun bits are not judged here
    always @*
    begin
        kind = `SDD_KIND_NONE;
        opcode_bad = 1'b0;
        field_bad = 1'b0;
        lba = `SDD_RST_LBA;
        case (b0)
            `SDD_OP_RESERVE:
            begin
                kind = `SDD_KIND_RESERVE;
                field_bad = b1[`SDD_RSV_EXTENT_BIT] | (b2 != 8'h00) | ({b3, b4} != 16'h0000);
            end
            `SDD_OP_REZERO:
            begin
                kind = `SDD_KIND_REZERO;
                field_bad = (b1[4:0] != 5'h00) | (b2 != 8'h00) | (b3 != 8'h00) | (b4 != 8'h00);
            end
            `SDD_OP_SEEK6:
            begin
                kind = `SDD_KIND_SEEK;
                lba = {11'h000, b1[`SDD_SEEK6_LBA_MSB:0], b2, b3};
                field_bad = (b4 != 8'h00);
            end
            `SDD_OP_SEEK10:
            begin
                kind = `SDD_KIND_SEEK;
                lba = {b2, b3, b4, b5};
                field_bad = (b1[4:0] != 5'h00) | (b6 != 8'h00) | (b7 != 8'h00) | (b8 != 8'h00);
            end
            `SDD_OP_DIAG:
            begin
                kind = `SDD_KIND_DIAG;
                field_bad = b1[`SDD_DIAG_DEV_OFFLINE_BIT]
                    | (self_test & (param_len != 16'h0000))
                    | (~self_test & b1[`SDD_DIAG_UNIT_OFFLINE_BIT])
                    | (b2 != 8'h00);
            end
            default:
            begin
                opcode_bad = 1'b1;
            end
        endcase
    end

endmodule

// file: hw/sdd_resv_holder.v
`timescale 1ns/1ps
`include "sdd_defines.vh"

// single reservation slot, no queue behind it
module sdd_resv_holder
(
    input wire mclk,
    input wire sys_rst,
    input wire grant,
    input wire [2:0] grant_id,
    input wire release_req,
    input wire [2:0] release_id,
    input wire bus_device_reset,
    input wire bus_reset,
    output reg reserved_r,
    output reg [2:0] holder_r
);

    // resets drop everything; a grant beats a release in the same cycle
    always @(posedge mclk)
    begin
        if (sys_rst | bus_reset | bus_device_reset)
        begin
            reserved_r <= 1'b0;
            holder_r <= `SDD_RST_HOLDER;
        end
        else if (grant)
        begin
            reserved_r <= 1'b1; // supersedes own earlier one
            holder_r <= grant_id;
        end
        else if (release_req && reserved_r && release_id == holder_r)
        begin
            reserved_r <= 1'b0;
        end
    end

endmodule

// file: hw/sdd_decoder.v
`timescale 1ns/1ps
`include "sdd_defines.vh"

// What this block does
// - reserve while others hold answers conflict
// - nonzero extent fields give 05h/24h
// - third-party reserve records the named device
// - device id ignored when flag clear
// - rezero sends heads to cylinder zero
// - six-byte seek address in bytes 1-3
// - good six-byte seek positions target cylinder
// - ten-byte seek takes 32-bit address
// - defective track defers alternate until access
// - invalid seek address gives 05h/21h
// - diagnostic only self-test, flag starts it
// - self-test never touches the medium
// - parameter length is bytes 3-4, msb first
// - device-offline set gives 05h/24h
// - self-test with nonzero length gives 05h/24h
// - non-holder commands get reservation conflict
// - release, device reset, bus reset drop reservation
module sdd_decoder
(
    input wire mclk,
    input wire sys_rst,
    input wire cdb_valid,
    input wire [79:0] cdb_data,
    input wire [2:0] cdb_initiator,
    input wire [31:0] max_lba,
    input wire lba_defective,
    input wire medium_access,
    input wire release_req,
    input wire [2:0] release_initiator,
    input wire bus_device_reset,
    input wire bus_reset,
    input wire sense_clear,
    output wire cdb_ready,
    output reg status_valid_r,
    output reg [7:0] status_code_r,
    output reg [3:0] sense_key_r,
    output reg [7:0] sense_code_r,
    output reg [31:0] lookup_lba_r,
    output reg seek_req_r,
    output reg [31:0] seek_lba_r,
    output reg seek_cylinder_only_r,
    output reg alt_pending_r,
    output reg rezero_req_r,
    output reg self_test_req_r,
    output reg self_test_no_medium_r,
    output wire unit_reserved,
    output wire [2:0] reserve_holder
);

    localparam ST_IDLE = 2'b00;
    localparam ST_LOOK = 2'b01;
    localparam ST_DECIDE = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [79:0] cdb_r;
    reg [2:0] init_r;

    wire [2:0] kind;
    wire opcode_bad;
    wire field_bad;
    wire [31:0] lba;
    wire third_party;
    wire [2:0] tp_id;
    wire self_test;

    wire resv_reserved;
    wire [2:0] resv_holder;

    // outcome of the decision cycle
    reg conflict;
    reg fail;
    reg [7:0] fail_code;
    reg grant;
    reg [2:0] grant_id;
    reg lba_bad;

    sdd_cdb_check u_check
    (
        .cdb(cdb_r),
        .kind(kind),
        .opcode_bad(opcode_bad),
        .field_bad(field_bad),
        .lba(lba),
        .third_party(third_party),
        .tp_id(tp_id),
        .self_test(self_test)
    );

    sdd_resv_holder u_resv
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .grant(grant),
        .grant_id(grant_id),
        .release_req(release_req),
        .release_id(release_initiator),
        .bus_device_reset(bus_device_reset),
        .bus_reset(bus_reset),
        .reserved_r(resv_reserved),
        .holder_r(resv_holder)
    );

    assign unit_reserved = resv_reserved;
    assign reserve_holder = resv_holder;
    // one command in flight; the sender waits on this
    assign cdb_ready = (state_r == ST_IDLE);

    // next-state: capture, look up the defect map, then decide
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (cdb_valid)
                begin
                    state_nxt = ST_LOOK;
                end
            end
            ST_LOOK:
            begin
                state_nxt = ST_DECIDE;
            end
            ST_DECIDE:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // decision logic; conflict first so a foreign initiator learns nothing of field errors
    always @*
    begin
        conflict = 1'b0;
        fail = 1'b0;
        fail_code = `SDD_ASC_NONE;
        grant = 1'b0;
        grant_id = init_r;
        lba_bad = (lba > max_lba);
        if (state_r == ST_DECIDE)
        begin
            if (resv_reserved && resv_holder != init_r)
            begin
                conflict = 1'b1;
            end
            else if (opcode_bad)
            begin
                fail = 1'b1;
                fail_code = `SDD_ASC_BAD_OPCODE;
            end
            else if (field_bad)
            begin
                fail = 1'b1;
                fail_code = `SDD_ASC_BAD_FIELD;
            end
            else if (kind == `SDD_KIND_SEEK && lba_bad)
            begin
                fail = 1'b1;
                fail_code = `SDD_ASC_BAD_LBA;
            end
            else if (kind == `SDD_KIND_RESERVE)
            begin
                grant = 1'b1;
                // id field only counts with the flag set
                grant_id = third_party ? tp_id : init_r;
            end
        end
    end

    // state and capture registers
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IDLE;
            cdb_r <= 80'h00000000000000000000;
            init_r <= 3'h0;
            lookup_lba_r <= `SDD_RST_LBA;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE && cdb_valid)
            begin
                cdb_r <= cdb_data;
                init_r <= cdb_initiator;
            end
            if (state_r == ST_LOOK)
            begin
                lookup_lba_r <= lba; // defect map answers by the decide cycle
            end
        end
    end

    // status and action pulses, only from the decide cycle
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            status_valid_r <= 1'b0;
            status_code_r <= `SDD_ST_GOOD;
            seek_req_r <= 1'b0;
            seek_lba_r <= `SDD_RST_LBA;
            seek_cylinder_only_r <= 1'b0;
            rezero_req_r <= 1'b0;
            self_test_req_r <= 1'b0;
            self_test_no_medium_r <= 1'b0;
        end
        else
        begin
            status_valid_r <= (state_r == ST_DECIDE);
            seek_req_r <= 1'b0;
            rezero_req_r <= 1'b0;
            self_test_req_r <= 1'b0;
            if (state_r == ST_DECIDE)
            begin
                if (conflict)
                begin
                    status_code_r <= `SDD_ST_CONFLICT;
                end
                else if (fail)
                begin
                    status_code_r <= `SDD_ST_CHECK;
                end
                else
                begin
                    status_code_r <= `SDD_ST_GOOD;
                end
                // actions fire only once every check has passed
                if (!conflict && !fail)
                begin
                    case (kind)
                        `SDD_KIND_SEEK:
                        begin
                            seek_req_r <= 1'b1;
                            seek_lba_r <= lba;
                            seek_cylinder_only_r <= lba_defective;
                        end
                        `SDD_KIND_REZERO:
                        begin
                            rezero_req_r <= 1'b1;
                        end
                        `SDD_KIND_DIAG:
                        begin
                            self_test_req_r <= self_test;
                            self_test_no_medium_r <= self_test;
                        end
                        default:
                        begin
                            seek_req_r <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // alternate track move stays owed until a medium command runs; set beats clear
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            alt_pending_r <= 1'b0;
        end
        else if (state_r == ST_DECIDE && !conflict && !fail && kind == `SDD_KIND_SEEK && lba_defective)
        begin
            alt_pending_r <= 1'b1;
        end
        else if (medium_access)
        begin
            alt_pending_r <= 1'b0;
        end
    end

    // sense held for request sense; a new check beats a clear in the same cycle
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sense_key_r <= `SDD_SK_NONE;
            sense_code_r <= `SDD_ASC_NONE;
        end
        else if (fail)
        begin
            sense_key_r <= `SDD_SK_ILLEGAL;
            sense_code_r <= fail_code;
        end
        else if (sense_clear)
        begin
            sense_key_r <= `SDD_SK_NONE;
            sense_code_r <= `SDD_ASC_NONE;
        end
    end

endmodule

// file: dv/sdd_far_model.sv
`timescale 1ns/1ps

// defect map and capacity seen by the decoder
module sdd_far_model
#(
    parameter [31:0] LAST_LBA = 32'h0000FFFF,
    parameter [31:0] BAD_LBA = 32'h00000100
)
(
    input wire [31:0] lookup_lba,
    output wire [31:0] max_lba,
    output wire lba_defective
);
    // one bad track only, enough to drive the deferred path
    assign max_lba = LAST_LBA;
    assign lba_defective = (lookup_lba == BAD_LBA);
endmodule

// file: dv/sdd_decoder_assertions.sv
`timescale 1ns/1ps

// protocol and outcome checks on the decoder ports
module sdd_decoder_chk
(
    input wire mclk,
    input wire sys_rst,
    input wire cdb_valid,
    input wire cdb_ready,
    input wire [31:0] max_lba,
    input wire bus_device_reset,
    input wire bus_reset,
    input wire status_valid_r,
    input wire [7:0] status_code_r,
    input wire [3:0] sense_key_r,
    input wire seek_req_r,
    input wire [31:0] seek_lba_r,
    input wire seek_cylinder_only_r,
    input wire alt_pending_r,
    input wire rezero_req_r,
    input wire self_test_req_r,
    input wire self_test_no_medium_r,
    input wire unit_reserved
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // busy for two cycles, then free with the answer
    sequence busy_s;
        !cdb_ready ##1 !cdb_ready ##1 cdb_ready;
    endsequence
    sequence answer_s;
        ##3 status_valid_r;
    endsequence
    take_answer_a: assert property (cdb_valid && cdb_ready |-> answer_s) else $error("no status after take");
    busy_window_a: assert property (cdb_valid && cdb_ready |=> busy_s) else $error("ready wrong after take");
    seek_good_a: assert property (seek_req_r |-> status_valid_r && status_code_r == 8'h00)
        else $error("seek without good status");
    seek_range_a: assert property (seek_req_r |-> seek_lba_r <= max_lba) else $error("seek past last block");
    conflict_quiet_a: assert property (status_valid_r && status_code_r == 8'h18
        |-> !seek_req_r && !rezero_req_r && !self_test_req_r) else $error("action on conflict");
    check_sense_a: assert property (status_valid_r && status_code_r == 8'h02 |-> sense_key_r == 4'h5
        && !seek_req_r && !rezero_req_r && !self_test_req_r) else $error("check without sense");
    rezero_good_a: assert property (rezero_req_r |-> status_valid_r && status_code_r == 8'h00)
        else $error("rezero without good status");
    // a self-test pulse must never travel with a head movement
    test_no_medium_a: assert property (self_test_req_r |-> self_test_no_medium_r && !seek_req_r
        && !rezero_req_r) else $error("self-test may access");
    alt_defer_a: assert property ($rose(alt_pending_r) |-> seek_req_r && seek_cylinder_only_r)
        else $error("alternate pending without seek");
    reset_drop_a: assert property (bus_reset || bus_device_reset |=> !unit_reserved) else $error("reservation kept");
endmodule

bind sdd_decoder sdd_decoder_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .cdb_valid(cdb_valid),
    .cdb_ready(cdb_ready), .max_lba(max_lba), .bus_device_reset(bus_device_reset), .bus_reset(bus_reset),
    .status_valid_r(status_valid_r), .status_code_r(status_code_r), .sense_key_r(sense_key_r),
    .seek_req_r(seek_req_r), .seek_lba_r(seek_lba_r), .seek_cylinder_only_r(seek_cylinder_only_r),
    .alt_pending_r(alt_pending_r), .rezero_req_r(rezero_req_r), .self_test_req_r(self_test_req_r),
    .self_test_no_medium_r(self_test_no_medium_r), .unit_reserved(unit_reserved));

// file: dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic mclk = 0, sys_rst = 1, cdb_valid = 0, medium_access = 0, release_req = 0;
    logic bus_device_reset = 0, bus_reset = 0, sense_clear = 0;
    logic [79:0] cdb_data = 80'h0;
    logic [2:0] cdb_initiator = 3'h0, release_initiator = 3'h0;
    wire [31:0] max_lba, lookup_lba_r, seek_lba_r;
    wire [7:0] status_code_r, sense_code_r;
    wire [3:0] sense_key_r;
    wire [2:0] reserve_holder;
    wire lba_defective, cdb_ready, status_valid_r, seek_req_r, seek_cylinder_only_r, alt_pending_r;
    wire rezero_req_r, self_test_req_r, self_test_no_medium_r, unit_reserved;
    integer fail_count = 0, tests_run = 0;

    sdd_far_model u_far (.lookup_lba(lookup_lba_r), .max_lba(max_lba), .lba_defective(lba_defective));
    sdd_decoder DUT (.mclk(mclk), .sys_rst(sys_rst), .cdb_valid(cdb_valid), .cdb_data(cdb_data),
        .cdb_initiator(cdb_initiator), .max_lba(max_lba), .lba_defective(lba_defective),
        .medium_access(medium_access), .release_req(release_req), .release_initiator(release_initiator),
        .bus_device_reset(bus_device_reset), .bus_reset(bus_reset), .sense_clear(sense_clear),
        .cdb_ready(cdb_ready), .status_valid_r(status_valid_r), .status_code_r(status_code_r),
        .sense_key_r(sense_key_r), .sense_code_r(sense_code_r), .lookup_lba_r(lookup_lba_r),
        .seek_req_r(seek_req_r), .seek_lba_r(seek_lba_r), .seek_cylinder_only_r(seek_cylinder_only_r),
        .alt_pending_r(alt_pending_r), .rezero_req_r(rezero_req_r), .self_test_req_r(self_test_req_r),
        .self_test_no_medium_r(self_test_no_medium_r), .unit_reserved(unit_reserved),
        .reserve_holder(reserve_holder));

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            tests_run++;
            if (got !== exp)
            begin
                fail_count++;
                $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    function [79:0] c6(input [7:0] b0, input [7:0] b1, input [7:0] b2, input [7:0] b3, input [7:0] b4);
        c6 = {32'h0, 8'h00, b4, b3, b2, b1, b0};
    endfunction

    function [79:0] c10(input [31:0] a);
        c10 = {32'h0, a[7:0], a[15:8], a[23:16], a[31:24], 8'h00, 8'h2B};
    endfunction

    // one command, wait for its status, compare status, sense and actions
    task cmd(input [79:0] c, input [2:0] id, input [7:0] st, input [11:0] sns, input [2:0] act);
        integer i;
        begin
            @(posedge mclk); #1;
            cdb_data = c;
            cdb_initiator = id;
            cdb_valid = 1;
            @(posedge mclk); #1;
            cdb_valid = 0;
            cdb_data = ~c; // stale bytes must not be reused
            i = 0;
            while (status_valid_r !== 1'b1 && i < 8)
            begin
                @(posedge mclk); #1;
                i = i + 1;
            end
            if (i == 8)
            begin
                fail_count++;
                $display("MISMATCH status_valid expected 1 seen 0");
                tally_and_finish;
            end
            chk("status", st, status_code_r);
            chk("action", act, {seek_req_r, rezero_req_r, self_test_req_r});
            if (st == 8'h02)
                chk("sense", sns, {sense_key_r, sense_code_r});
        end
    endtask

    // one-cycle pulse on {release, device reset, bus reset, medium access, sense clear}
    task pls(input [4:0] m);
        begin
            @(posedge mclk); #1;
            {release_req, bus_device_reset, bus_reset, medium_access, sense_clear} = m;
            @(posedge mclk); #1;
            {release_req, bus_device_reset, bus_reset, medium_access, sense_clear} = 5'h00;
        end
    endtask

    integer k;
    initial
    begin
        repeat (10) @(posedge mclk);
        #1 sys_rst = 0;
        chk("reserved", 0, unit_reserved);
        chk("holder", 0, reserve_holder);
        // rezero and its reserved bytes
        cmd(c6(8'h01, 8'h00, 8'h00, 8'h00, 8'h00), 0, 8'h00, 0, 3'b010);
        cmd(c6(8'h01, 8'h00, 8'h10, 8'h00, 8'h00), 0, 8'h02, 12'h524, 3'b000);
        cmd(c6(8'h00, 8'h00, 8'h00, 8'h00, 8'h00), 0, 8'h02, 12'h520, 3'b000);
        pls(5'h01);
        chk("sense clear", 0, {sense_key_r, sense_code_r});
        $display("test rezero done");
        // six-byte seek, unit bits on top of byte 1
        cmd(c6(8'h0B, 8'hE0, 8'hAB, 8'hCD, 8'h00), 0, 8'h00, 0, 3'b100);
        chk("seek6 lba", 32'h0000ABCD, seek_lba_r);
        cmd(c6(8'h0B, 8'h01, 8'hAB, 8'hCD, 8'h00), 0, 8'h02, 12'h521, 3'b000);
        // ten-byte seek at the boundary and one past it
        cmd(c10(32'h0000FFFF), 0, 8'h00, 0, 3'b100);
        chk("seek10 lba", 32'h0000FFFF, seek_lba_r);
        chk("cyl only", 0, seek_cylinder_only_r);
        cmd(c10(32'h00010000), 0, 8'h02, 12'h521, 3'b000);
        cmd(c10(32'h00000100), 0, 8'h00, 0, 3'b100);
        chk("cyl only", 1, seek_cylinder_only_r);
        chk("alt set", 1, alt_pending_r);
        chk("lookup", 32'h00000100, lookup_lba_r);
        pls(5'h02);
        chk("alt clear", 0, alt_pending_r);
        $display("test seek done");
        // diagnostic flags and parameter length
        cmd(c6(8'h1D, 8'h04, 8'h00, 8'h00, 8'h00), 0, 8'h00, 0, 3'b001);
        chk("no medium", 1, self_test_no_medium_r);
        cmd(c6(8'h1D, 8'h06, 8'h00, 8'h00, 8'h00), 0, 8'h02, 12'h524, 3'b000);
        cmd(c6(8'h1D, 8'h04, 8'h00, 8'h00, 8'h01), 0, 8'h02, 12'h524, 3'b000);
        cmd(c6(8'h1D, 8'h04, 8'h00, 8'h01, 8'h00), 0, 8'h02, 12'h524, 3'b000);
        cmd(c6(8'h1D, 8'h00, 8'h00, 8'h00, 8'h00), 0, 8'h00, 0, 3'b000);
        cmd(c6(8'h1D, 8'h01, 8'h00, 8'h00, 8'h00), 0, 8'h02, 12'h524, 3'b000);
        $display("test diagnostic done");
        // reserve fields that must be zero
        cmd(c6(8'h16, 8'h01, 8'h00, 8'h00, 8'h00), 1, 8'h02, 12'h524, 3'b000);
        cmd(c6(8'h16, 8'h00, 8'h01, 8'h00, 8'h00), 1, 8'h02, 12'h524, 3'b000);
        cmd(c6(8'h16, 8'h00, 8'h00, 8'h00, 8'h01), 1, 8'h02, 12'h524, 3'b000);
        chk("reserved", 0, unit_reserved);
        // id field ignored with flag clear, other initiator refused
        cmd(c6(8'h16, 8'h0E, 8'h00, 8'h00, 8'h00), 1, 8'h00, 0, 3'b000);
        chk("holder", 1, reserve_holder);
        cmd(c10(32'h00000010), 2, 8'h18, 0, 3'b000);
        cmd(c6(8'h16, 8'h00, 8'h00, 8'h00, 8'h00), 2, 8'h18, 0, 3'b000);
        chk("holder", 1, reserve_holder);
        // a release from someone else must leave the holder alone
        release_initiator = 3'h2;
        pls(5'h10);
        chk("kept", 1, unit_reserved);
        release_initiator = 3'h1;
        pls(5'h10);
        chk("released", 0, unit_reserved);
        // third party reservation refuses the initiator that made it, then released by the third party
        cmd(c6(8'h16, 8'h1A, 8'h00, 8'h00, 8'h00), 1, 8'h00, 0, 3'b000);
        chk("holder", 5, reserve_holder);
        cmd(c6(8'h01, 8'h00, 8'h00, 8'h00, 8'h00), 1, 8'h18, 0, 3'b000);
        release_initiator = 3'h5;
        pls(5'h10);
        chk("released", 0, unit_reserved);
        // both reset kinds drop a held reservation
        for (k = 0; k < 2; k++)
        begin
            cmd(c6(8'h16, 8'h00, 8'h00, 8'h00, 8'h00), 3, 8'h00, 0, 3'b000);
            chk("reserved", 1, unit_reserved);
            pls(k ? 5'h04 : 5'h08);
            chk("reset drop", 0, unit_reserved);
        end
        $display("test reserve done");
        tally_and_finish;
    end
endmodule
